//--- logic/timer_compare_pkg.sv
// shared register map, field positions and reset values of the timer/compare unit
package timer_compare_pkg;
  // register byte offsets on the avalon slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TMR_X = 8'h04;
  localparam logic [7:0] OFS_TMR_A = 8'h08;
  localparam logic [7:0] OFS_TMR_B = 8'h0C;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_CMP_BASE = 8'h20;
  // control register fields
  localparam int CT_RUN = 0;
  localparam int CT_EDGE = 3;
  localparam int CT_WLO_A = 4;
  localparam int CT_WLO_B = 5;
  localparam int CT_XMODE = 6;
  localparam int CT_XSRC = 8;
  localparam int CT_ASRC = 10;
  localparam int CT_BSRC = 12;
  // compare control fields
  localparam int CC_TRIG = 0;
  localparam int CC_SEL = 4;
  localparam int CC_ISRC = 8;
  // status / mask bits, compare matches follow from ST_MATCH upward
  localparam int ST_UF_X = 0;
  localparam int ST_UF_A = 1;
  localparam int ST_UF_B = 2;
  localparam int ST_EVENT = 3;
  localparam int ST_MATCH = 4;
  // reset values and the unmapped read value
  localparam logic [7:0] TMR_RESET = 8'hFF;
  localparam logic [7:0] CMP_RESET = 8'hFF;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // prescaler tap used by timer b when not chained to timer a
  localparam logic [1:0] B_PRE_SEL = 2'h2;
  // timer x operating modes
  typedef enum logic [1:0] {
    XM_TIMER = 2'h0,
    XM_PULSE = 2'h1,
    XM_EVENT = 2'h2,
    XM_WIDTH = 2'h3
  } xmode_t;
endpackage : timer_compare_pkg

//--- logic/pin_sync.sv
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pin side and synchronised level
  input wire logic pin_async,
  output logic pin_sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;
  sync_t st_reg;
  sync_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_async;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_sync_out = st_reg.s2;
endmodule : pin_sync

//--- logic/reload_timer.sv
// down-counting reload timer with latch and counter
`timescale 1ns/1ps
module reload_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // counting control
  input wire logic run,
  input wire logic tick,
  // software write
  input wire logic wr,
  input wire logic wr_latch_only,
  input wire logic [W-1:0] wr_data,
  // state and events
  output logic [W-1:0] count,
  output logic [W-1:0] latch,
  output logic underflow
);
  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] latch;
  } tmr_t;
  tmr_t st_reg;
  tmr_t st_next;

  if (W < 1 || W > 16) begin : g_chk
    $error("reload_timer: W out of range");
  end

  // zero reached on a tick: reload next, giving n+1 ticks per period
  assign underflow = run && tick && (st_reg.count == '0);

  // a write beats a tick in the same cycle
  always_comb begin
    st_next = st_reg;
    if (run && tick) begin
      st_next.count = underflow ? st_reg.latch : st_reg.count - 1'b1;
    end
    if (wr) begin
      st_next.latch = wr_data;
      if (!wr_latch_only) begin
        st_next.count = wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;
  assign latch = st_reg.latch;
endmodule : reload_timer

//--- logic/timer_compare_unit.sv
// reload timers x/a/b with output compare channels behind an avalon-mm slave
//
// Overview of operation
// - reload value n divides source by n+1
// - event flag on falling, or rising when set
// - edge select change may itself raise flag
// - write control bit: latch only, else both
// - compare write while source stopped loads latch
// - latch above reload never matches, output frozen
// - latch within reload matches, interrupts if enabled
// - trigger disabled freezes output, matches still flag
`timescale 1ns/1ps
module timer_compare_unit #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // pins
  input wire logic event_counter_pin_in,
  output logic event_counter_pin_out,
  output logic event_counter_pin_oe,
  output logic timer_pulse_out_pin,
  output logic [NCH-1:0] wave_out
);
  localparam int NL = 2 * NCH;
  localparam int ST_W = timer_compare_pkg::ST_MATCH + NL;

  if (NCH < 1 || NCH > 4) begin : g_chk
    $error("timer_compare_unit: NCH must be 1 to 4");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic [2:0] run;
    logic edge_rise;
    logic wlo_a;
    logic wlo_b;
    logic [1:0] xmode;
    logic [1:0] xsrc;
    logic [1:0] asrc;
    logic bsrc;
    logic [NCH-1:0] trig;
    logic [NCH-1:0] csel;
    logic [NL-1:0] isrc;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [NL-1:0][7:0] cmp_reg;
    logic [NL-1:0][7:0] cmp_lat;
    logic [NCH-1:0] wave;
    logic pulse;
    logic pin_oe;
    logic [7:0] pre;
    logic eff_prev;
  } state_t;
  state_t st_reg;
  state_t st_next;

  // prescaler tap select: undivided, /8, /16, /256
  function automatic logic pre_tick(input logic [7:0] pre, input logic [1:0] sel);
    logic t;
    t = 1'b1;
    case (sel)
      2'h0: t = 1'b1;
      2'h1: t = (pre[2:0] == 3'h7);
      2'h2: t = (pre[3:0] == 4'hF);
      2'h3: t = (pre == 8'hFF);
      default: t = 1'b1;
    endcase
    return t;
  endfunction : pre_tick

  logic pin_s;
  logic eff;
  logic ev_edge;
  logic tick_x;
  logic tick_a;
  logic tick_b;
  logic uf_x;
  logic uf_a;
  logic uf_b;
  logic wr_now;
  logic wr_x;
  logic wr_a;
  logic wr_b;
  logic cmp_hit;
  logic [2:0] cmp_idx;
  logic [7:0] cnt_x;
  logic [7:0] cnt_a;
  logic [7:0] cnt_b;
  logic [7:0] lat_x;
  logic [7:0] lat_a;
  logic [7:0] lat_b;
  logic [NL-1:0] match;
  logic [NL-1:0] over;

  pin_sync u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pin_async(event_counter_pin_in),
    .pin_sync_out(pin_s)
  );

  // edge select flips the sensed level, so a change can look like an edge
  assign eff = pin_s ^ st_reg.edge_rise;
  assign ev_edge = st_reg.eff_prev & ~eff;

  // count sources; changes are only safe with the timer stopped
  always_comb begin
    case (st_reg.xmode)
      timer_compare_pkg::XM_EVENT: tick_x = ev_edge;
      timer_compare_pkg::XM_WIDTH: tick_x = pre_tick(st_reg.pre, st_reg.xsrc) & eff;
      default: tick_x = pre_tick(st_reg.pre, st_reg.xsrc);
    endcase
  end
  assign tick_a = pre_tick(st_reg.pre, st_reg.asrc);
  assign tick_b = st_reg.bsrc ? uf_a : pre_tick(st_reg.pre, timer_compare_pkg::B_PRE_SEL);

  // bus writes take effect on the edge where waitrequest is low
  assign wr_now = st_reg.ack & avs_write;
  assign wr_x = wr_now && (avs_address == timer_compare_pkg::OFS_TMR_X);
  assign wr_a = wr_now && (avs_address == timer_compare_pkg::OFS_TMR_A);
  assign wr_b = wr_now && (avs_address == timer_compare_pkg::OFS_TMR_B);
  assign cmp_idx = avs_address[4:2];
  assign cmp_hit = (avs_address[7:5] == timer_compare_pkg::OFS_CMP_BASE[7:5]) && (32'(cmp_idx) < NL);

  reload_timer #(.W(8)) u_tmr_x (
    .clk(clk),
    .srst(srst),
    .run(st_reg.run[0]),
    .tick(tick_x),
    .wr(wr_x),
    .wr_latch_only(1'b0),
    .wr_data(avs_writedata[7:0]),
    .count(cnt_x),
    .latch(lat_x),
    .underflow(uf_x)
  );

  reload_timer #(.W(8)) u_tmr_a (
    .clk(clk),
    .srst(srst),
    .run(st_reg.run[1]),
    .tick(tick_a),
    .wr(wr_a),
    .wr_latch_only(st_reg.wlo_a),
    .wr_data(avs_writedata[7:0]),
    .count(cnt_a),
    .latch(lat_a),
    .underflow(uf_a)
  );

  reload_timer #(.W(8)) u_tmr_b (
    .clk(clk),
    .srst(srst),
    .run(st_reg.run[2]),
    .tick(tick_b),
    .wr(wr_b),
    .wr_latch_only(st_reg.wlo_b),
    .wr_data(avs_writedata[7:0]),
    .count(cnt_b),
    .latch(lat_b),
    .underflow(uf_b)
  );

  // compare: latch above reload never matches, even when it equals the count
  always_comb begin
    for (int y = 0; y < NL; y++) begin
      logic sb;
      sb = st_reg.csel[y/2];
      over[y] = st_reg.cmp_lat[y] > (sb ? lat_b : lat_a);
      match[y] = (sb ? (st_reg.run[2] & tick_b) : (st_reg.run[1] & tick_a))
        && (st_reg.cmp_lat[y] == (sb ? cnt_b : cnt_a)) && !over[y];
    end
  end

  // next state: bus, control, compare outputs, flags
  always_comb begin
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;
    logic [31:0] rd;
    st_next = st_reg;
    ev = '0;
    clr = '0;
    rd = timer_compare_pkg::RD_UNMAPPED;
    st_next.pre = st_reg.pre + 8'h01;
    st_next.eff_prev = eff;
    // one wait cycle per access, then a one-cycle answer
    st_next.ack = (avs_read | avs_write) & ~st_reg.ack;
    case (avs_address)
      timer_compare_pkg::OFS_CTRL: begin
        rd[timer_compare_pkg::CT_RUN +: 3] = st_reg.run;
        rd[timer_compare_pkg::CT_EDGE] = st_reg.edge_rise;
        rd[timer_compare_pkg::CT_WLO_A] = st_reg.wlo_a;
        rd[timer_compare_pkg::CT_WLO_B] = st_reg.wlo_b;
        rd[timer_compare_pkg::CT_XMODE +: 2] = st_reg.xmode;
        rd[timer_compare_pkg::CT_XSRC +: 2] = st_reg.xsrc;
        rd[timer_compare_pkg::CT_ASRC +: 2] = st_reg.asrc;
        rd[timer_compare_pkg::CT_BSRC] = st_reg.bsrc;
      end
      timer_compare_pkg::OFS_TMR_X: rd[15:0] = {lat_x, cnt_x};
      timer_compare_pkg::OFS_TMR_A: rd[15:0] = {lat_a, cnt_a};
      timer_compare_pkg::OFS_TMR_B: rd[15:0] = {lat_b, cnt_b};
      timer_compare_pkg::OFS_CMP_CTRL: begin
        rd[timer_compare_pkg::CC_TRIG +: NCH] = st_reg.trig;
        rd[timer_compare_pkg::CC_SEL +: NCH] = st_reg.csel;
        rd[timer_compare_pkg::CC_ISRC +: NL] = st_reg.isrc;
        rd[16 +: NCH] = st_reg.wave;
      end
      timer_compare_pkg::OFS_STATUS: rd[ST_W-1:0] = st_reg.status;
      timer_compare_pkg::OFS_MASK: rd[ST_W-1:0] = st_reg.mask;
      default: begin
        if (cmp_hit) begin
          rd[7:0] = st_reg.cmp_reg[cmp_idx];
        end
      end
    endcase
    if (avs_read && !st_reg.ack) begin
      st_next.rdata = rd;
    end
    if (wr_now) begin
      case (avs_address)
        timer_compare_pkg::OFS_CTRL: begin
          st_next.run = avs_writedata[timer_compare_pkg::CT_RUN +: 3];
          st_next.edge_rise = avs_writedata[timer_compare_pkg::CT_EDGE];
          st_next.wlo_a = avs_writedata[timer_compare_pkg::CT_WLO_A];
          st_next.wlo_b = avs_writedata[timer_compare_pkg::CT_WLO_B];
          st_next.xmode = avs_writedata[timer_compare_pkg::CT_XMODE +: 2];
          st_next.xsrc = avs_writedata[timer_compare_pkg::CT_XSRC +: 2];
          st_next.asrc = avs_writedata[timer_compare_pkg::CT_ASRC +: 2];
          st_next.bsrc = avs_writedata[timer_compare_pkg::CT_BSRC];
        end
        timer_compare_pkg::OFS_CMP_CTRL: begin
          st_next.trig = avs_writedata[timer_compare_pkg::CC_TRIG +: NCH];
          st_next.csel = avs_writedata[timer_compare_pkg::CC_SEL +: NCH];
          st_next.isrc = avs_writedata[timer_compare_pkg::CC_ISRC +: NL];
        end
        timer_compare_pkg::OFS_STATUS: clr = avs_writedata[ST_W-1:0];
        timer_compare_pkg::OFS_MASK: st_next.mask = avs_writedata[ST_W-1:0];
        default: begin
          if (cmp_hit) begin
            st_next.cmp_reg[cmp_idx] = avs_writedata[7:0];
          end
        end
      endcase
    end
    // compare latches: load on source underflow, or at once while stopped
    for (int y = 0; y < NL; y++) begin
      logic sb;
      sb = st_reg.csel[y/2];
      if (sb ? uf_b : uf_a) begin
        st_next.cmp_lat[y] = st_reg.cmp_reg[y];
      end
      if (wr_now && cmp_hit && (32'(cmp_idx) == y) && !(sb ? st_reg.run[2] : st_reg.run[1])) begin
        st_next.cmp_lat[y] = avs_writedata[7:0];
      end
    end
    // latch x0 drives high, x1 drives low; disabled trigger freezes level
    for (int c = 0; c < NCH; c++) begin
      if (st_reg.trig[c] && match[2*c]) begin
        st_next.wave[c] = 1'b1;
      end
      if (st_reg.trig[c] && match[2*c+1]) begin
        st_next.wave[c] = 1'b0;
      end
    end
    // pulse output toggles per timer x underflow in pulse mode
    if (uf_x && (st_reg.xmode == timer_compare_pkg::XM_PULSE)) begin
      st_next.pulse = ~st_reg.pulse;
    end
    st_next.pin_oe = (st_next.xmode == timer_compare_pkg::XM_PULSE);
    ev[timer_compare_pkg::ST_UF_X] = uf_x;
    ev[timer_compare_pkg::ST_UF_A] = uf_a;
    ev[timer_compare_pkg::ST_UF_B] = uf_b;
    ev[timer_compare_pkg::ST_EVENT] = ev_edge;
    ev[timer_compare_pkg::ST_MATCH +: NL] = match & st_reg.isrc;
    // set wins over a same-cycle write-one-to-clear
    st_next.status = (st_reg.status & ~clr) | ev;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.cmp_reg <= {NL{timer_compare_pkg::CMP_RESET}};
      st_reg.cmp_lat <= {NL{timer_compare_pkg::CMP_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = ~st_reg.ack;
  assign irq = st_reg.irq;
  assign wave_out = st_reg.wave;
  assign timer_pulse_out_pin = st_reg.pulse;
  assign event_counter_pin_out = st_reg.pulse;
  assign event_counter_pin_oe = st_reg.pin_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_reload;
    uf_a && !wr_a |=> cnt_a == $past(lat_a);
  endproperty
  a_reload: assert property (p_reload) else $error("timer a did not reload");

  property p_edge_flag;
    ev_edge |=> st_reg.status[timer_compare_pkg::ST_EVENT];
  endproperty
  a_edge_flag: assert property (p_edge_flag) else $error("event edge not flagged");

  property p_latch_only;
    wr_a && st_reg.wlo_a && !st_reg.run[1] |=> $stable(cnt_a) && lat_a == $past(avs_writedata[7:0]);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("latch-only write hit counter");

  property p_both;
    wr_a && !st_reg.wlo_a |=> cnt_a == $past(avs_writedata[7:0]);
  endproperty
  a_both: assert property (p_both) else $error("write missed counter");

  property p_cmp_load;
    wr_now && cmp_hit && !st_reg.run[1] && !st_reg.run[2] |=> st_reg.cmp_lat[$past(cmp_idx)] == $past(avs_writedata[7:0]);
  endproperty
  a_cmp_load: assert property (p_cmp_load) else $error("stopped compare write not loaded");

  property p_no_over;
    match[0] |-> st_reg.cmp_lat[0] <= (st_reg.csel[0] ? lat_b : lat_a);
  endproperty
  a_no_over: assert property (p_no_over) else $error("match beyond reload");

  property p_frozen;
    1'b1 |=> ((st_reg.wave ^ $past(st_reg.wave)) & ~$past(st_reg.trig)) == '0;
  endproperty
  a_frozen: assert property (p_frozen) else $error("disabled channel moved");

  property p_match_irq;
    (match & st_reg.isrc) != '0 |=> (st_reg.status[timer_compare_pkg::ST_MATCH +: NL] & $past(match & st_reg.isrc)) == $past(match & st_reg.isrc);
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("match not flagged");

  property p_uf_flag;
    uf_x |=> st_reg.status[timer_compare_pkg::ST_UF_X] ##1 st_reg.irq || !st_reg.mask[timer_compare_pkg::ST_UF_X]
      || !st_reg.status[timer_compare_pkg::ST_UF_X];
  endproperty
  a_uf_flag: assert property (p_uf_flag) else $error("underflow flag or irq missing");

  property p_bus;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
endmodule : timer_compare_unit

//--- testbench/pin_partner.sv
// far-side model of the event pin: resolves the shared wire and drives the sensed level
`timescale 1ns/1ps
module pin_partner (
  // clock
  input wire logic clk,
  // level the bench wants on the wire while the device only listens
  input wire logic level_cmd,
  // device side of the shared pin
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in
);
  initial pin_in = 1'b1;
  // pulse mode: device owns the wire; width/event mode: far side drives it
  always @(posedge clk) begin
    pin_in <= pin_oe ? pin_out : level_cmd;
  end
endmodule : pin_partner

//--- testbench/testbench.sv
// self-checking bench for the timer/compare unit
`timescale 1ns/1ps
module testbench;
  logic clk, srst, avs_read, avs_write, irq, level_cmd, pin_in, pin_out, pin_oe, pulse_pin;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest;
  logic [3:0] wave_out;
  int n_mismatch = 0;
  int comparisons = 0;

  timer_compare_unit #(.NCH(4)) u_timer_compare_unit (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .event_counter_pin_in(pin_in),
    .event_counter_pin_out(pin_out), .event_counter_pin_oe(pin_oe), .timer_pulse_out_pin(pulse_pin),
    .wave_out(wave_out));
  pin_partner u_pin_partner (.clk(clk), .level_cmd(level_cmd), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // one avalon access; request held until waitrequest is sampled low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(1'b1, 1'b0, "bus hang");
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus_xfer

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd_reg

  task automatic wait_toggle(output int gap);
    logic prev;
    gap = 0;
    prev = pulse_pin;
    do begin
      @(negedge clk);
      gap++;
    end while (pulse_pin === prev && gap < 100);
  endtask : wait_toggle

  // reset values and an unmapped read
  task automatic test_reset;
    rd_reg(timer_compare_pkg::OFS_TMR_X, rd);
    chk(rd, 32'h0000_FFFF, "timer x reset");
    rd_reg(8'h1C, rd);
    chk(rd, timer_compare_pkg::RD_UNMAPPED, "unmapped read");
  endtask : test_reset

  // pulse mode period of n+1 source ticks, underflow flag, mask and w1c
  task automatic test_divide;
    int gap;
    wr_reg(timer_compare_pkg::OFS_TMR_X, 32'h0000_0003);
    wr_reg(timer_compare_pkg::OFS_MASK, 32'h0000_0001);
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0041); // undivided source, bench clock taken as ceramic
    wait_toggle(gap);
    wait_toggle(gap);
    chk(gap, 4, "pulse period");
    chk({pin_oe, pin_out}, {1'b1, pulse_pin}, "pin drive in pulse mode");
    chk(irq, 1'b1, "underflow irq");
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0000); // stopped before source change
    wr_reg(timer_compare_pkg::OFS_STATUS, 32'h0000_FFFF);
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
    chk(rd, 32'h0000_0000, "status after clear");
    chk(irq, 1'b0, "irq after clear");
  endtask : test_divide

  // latch-only write leaves the counter, plain write loads both
  task automatic test_write_ctl;
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0010);
    wr_reg(timer_compare_pkg::OFS_TMR_A, 32'h0000_0021); // timer a stopped before access
    rd_reg(timer_compare_pkg::OFS_TMR_A, rd);
    chk(rd, 32'h0000_21FF, "latch only write");
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0000);
    wr_reg(timer_compare_pkg::OFS_TMR_A, 32'h0000_0009);
    rd_reg(timer_compare_pkg::OFS_TMR_A, rd);
    chk(rd, 32'h0000_0909, "latch and counter write");
  endtask : test_write_ctl

  // falling edge with select 0, rising edge with select 1
  task automatic test_edge;
    wr_reg(timer_compare_pkg::OFS_STATUS, 32'h0000_0008);
    level_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
    chk(rd[3], 1'b1, "falling edge flag");
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0008);
    wr_reg(timer_compare_pkg::OFS_STATUS, 32'h0000_0008); // clear what the switch may raise
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
    chk(rd[3], 1'b0, "flag cleared after switch");
    level_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
    chk(rd[3], 1'b1, "rising edge flag");
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0000);
  endtask : test_edge

  // run timer a for a while and report whether channel 0 ever went high
  task automatic run_a(output logic seen_hi);
    seen_hi = 1'b0;
    wr_reg(timer_compare_pkg::OFS_STATUS, 32'h0000_FFFF);
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0002);
    repeat (60) begin
      @(negedge clk);
      seen_hi = seen_hi | (wave_out[0] === 1'b1);
    end
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0000);
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
  endtask : run_a

  // compare: out-of-range latch never matches, disabled trigger freezes the wave
  task automatic test_compare;
    logic hi;
    wr_reg(timer_compare_pkg::OFS_CMP_BASE, 32'h0000_0003); // loads at once, a stopped
    wr_reg(timer_compare_pkg::OFS_CMP_BASE + 8'h04, 32'h0000_0014); // differs from pair
    wr_reg(timer_compare_pkg::OFS_CMP_CTRL, 32'h0000_0300);
    run_a(hi);
    chk(rd[5:4], 2'b01, "match flags with one latch above reload");
    chk(hi, 1'b0, "wave frozen with trigger off");
    wr_reg(timer_compare_pkg::OFS_CMP_BASE + 8'h04, 32'h0000_0007);
    wr_reg(timer_compare_pkg::OFS_CMP_CTRL, 32'h0000_0301);
    run_a(hi);
    chk(rd[5:4], 2'b11, "both latches match");
    chk(hi, 1'b1, "wave driven with trigger on");
  endtask : test_compare

  // timer b chained to timer a underflows, then timer x counting pin edges
  task automatic test_chain;
    wr_reg(timer_compare_pkg::OFS_TMR_A, 32'h0000_0001);
    wr_reg(timer_compare_pkg::OFS_TMR_B, 32'h0000_0002); // timer b stopped before access
    rd_reg(timer_compare_pkg::OFS_TMR_B, rd);
    chk(rd, 32'h0000_0202, "timer b write");
    wr_reg(timer_compare_pkg::OFS_STATUS, 32'h0000_FFFF);
    // prescaler source could not underflow b in this span, chaining can
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_1006);
    repeat (20) @(posedge clk);
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0000);
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
    chk(rd[2:1], 2'b11, "timer b counts timer a underflows");
    wr_reg(timer_compare_pkg::OFS_TMR_X, 32'h0000_0001);
    wr_reg(timer_compare_pkg::OFS_STATUS, 32'h0000_FFFF);
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0081);
    repeat (2) begin
      level_cmd <= 1'b0;
      repeat (8) @(posedge clk);
      level_cmd <= 1'b1;
      repeat (8) @(posedge clk);
    end
    wr_reg(timer_compare_pkg::OFS_CTRL, 32'h0000_0000);
    rd_reg(timer_compare_pkg::OFS_STATUS, rd);
    chk(rd[3:0], 4'b1001, "event mode underflow after two edges");
    rd_reg(timer_compare_pkg::OFS_TMR_X, rd);
    chk(rd, 32'h0000_0101, "event mode reload");
  endtask : test_chain

  task automatic wrap_up;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    level_cmd = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    test_reset;
    test_divide;
    test_write_ctl;
    test_edge;
    test_compare;
    test_chain;
    wrap_up;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule : testbench
